// >>> rtl/ctpu_map.vh
`ifndef CTPU_MAP_VH
`define CTPU_MAP_VH
`define CTPU_OFS_CTRL_A 4'h0
`define CTPU_OFS_CTRL_B 4'h4
`define CTPU_OFS_COUNT_LOW 4'h8
`define CTPU_OFS_COUNT_HIGH 4'hC
`define CTPU_OFS_MATCH_LOW 5'h10
`define CTPU_OFS_MATCH_HIGH 5'h14
`define CTPU_RST_CTRL_A 8'h00
`define CTPU_RST_CTRL_B 8'h00
`define CTPU_RST_MATCH 10'h000
`define CTPU_RST_COUNT 10'h000
`define CTPU_A_PAUSE 7
`define CTPU_A_CLK_HI 6
`define CTPU_A_CLK_LO 4
`define CTPU_A_ON 3
`define CTPU_A_PER_HI 2
`define CTPU_A_PER_LO 0
`define CTPU_B_MODE_HI 7
`define CTPU_B_MODE_LO 6
`define CTPU_B_FUNC_HI 5
`define CTPU_B_FUNC_LO 4
`define CTPU_B_INIT 3
`define CTPU_B_POL 2
`define CTPU_B_SWAP 1
`define CTPU_B_CLR 0
`define CTPU_MODE_CMP 2'h0
`define CTPU_MODE_PWM 2'h2
`define CTPU_MODE_TMR 2'h3
`define CTPU_FN_NONE 2'h0
`define CTPU_FN_LOW 2'h1
`define CTPU_FN_HIGH 2'h2
`define CTPU_FN_TOG 2'h3
`define CTPU_DIV_SYS4 8'h03
`define CTPU_DIV_H16 8'h0F
`define CTPU_DIV_H64 8'h3F
`define CTPU_RESP_OKAY 2'h0
`define CTPU_RESP_SLVERR 2'h2
`endif

// >>> rtl/ctpu_timer.v
// Contract
// - 10-bit up counter, one step per tick
// - period compare: 3 bits vs count[9:7]
// - match compare: all 10 counter bits
// - no direct load; on-rise clears count
// - clear on overflow or selected match
// - pause holds count, resume from it
// - clock select codes; 110/111 unusable
// - off stops counting, keeps residual value
// - on-rise forces output to initial level
// - period code times 128, zero is 1024
// - period zero runs to overflow
// - clear-source zero: period match clears
// - mode: 00 compare, 10 PWM, 11 timer
// - timer mode output is undefined
// - inverted second output, internal only
// - count read-only pair, match read/write pair
// - low bytes via 8-bit holding buffer
// - clear-source one: match clears, not PWM
// - compare mode output function on match
// - init level, or PWM active level
`include "ctpu_map.vh"
`timescale 1ns/100ps
`default_nettype none
module ctpu_timer (
	input wire aclk,
	input wire aresetn,
	input wire high_clk_en,
	input wire sub_clk,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg timer_out,
	output wire timer_out_inv,
	output reg period_match_evt,
	output reg match_evt
);
	reg [7:0] ctrl_a_r;
	reg [7:0] ctrl_b_r;
	reg [9:0] count_r;
	reg [9:0] match_r;
	reg [7:0] hold_buf_r;
	reg on_d_r;
	reg out_r;
	reg [7:0] div_r;
	reg sub_s1_r;
	reg sub_s2_r;
	reg sub_s3_r;
	reg [31:0] awaddr_r;
	reg aw_have_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg w_have_r;

	wire pause_ctl = ctrl_a_r[`CTPU_A_PAUSE];
	wire [2:0] clk_sel = ctrl_a_r[`CTPU_A_CLK_HI:`CTPU_A_CLK_LO];
	wire counter_on = ctrl_a_r[`CTPU_A_ON];
	wire [2:0] period_sel = ctrl_a_r[`CTPU_A_PER_HI:`CTPU_A_PER_LO];
	wire [1:0] op_mode_sel = ctrl_b_r[`CTPU_B_MODE_HI:`CTPU_B_MODE_LO];
	wire [1:0] out_func_sel = ctrl_b_r[`CTPU_B_FUNC_HI:`CTPU_B_FUNC_LO];
	wire out_init_level = ctrl_b_r[`CTPU_B_INIT];
	wire out_polarity = ctrl_b_r[`CTPU_B_POL];
	wire duty_period_swap = ctrl_b_r[`CTPU_B_SWAP];
	wire clear_src_sel = ctrl_b_r[`CTPU_B_CLR];
	wire is_pwm = (op_mode_sel == `CTPU_MODE_PWM);
	wire is_cmp = (op_mode_sel == `CTPU_MODE_CMP);
	wire on_rise = counter_on & ~on_d_r;

	// tick source; high_clk_en is a strobe at the high clock rate
	reg [7:0] div_max;
	reg tick_src;
	always @* begin
		div_max = `CTPU_DIV_SYS4;
		tick_src = 1'b1;
		case (clk_sel)
		3'h0: begin
			div_max = `CTPU_DIV_SYS4;
			tick_src = 1'b1;
		end
		3'h1: begin
			div_max = 8'h00;
			tick_src = 1'b1;
		end
		3'h2: begin
			div_max = `CTPU_DIV_H16;
			tick_src = high_clk_en;
		end
		3'h3: begin
			div_max = `CTPU_DIV_H64;
			tick_src = high_clk_en;
		end
		3'h4, 3'h5: begin
			div_max = 8'h00;
			tick_src = sub_s2_r & ~sub_s3_r;
		end
		default: begin
			// unusable codes stop the counter rather than guess
			div_max = 8'h00;
			tick_src = 1'b0;
		end
		endcase
	end
	wire tick = tick_src & (div_r == div_max);

	wire run = counter_on & ~pause_ctl;
	// compare the value the counter is about to take, so the clear lands
	// on the code*128th tick instead of one tick later
	wire [9:0] cnt_inc = count_r + 10'h001;
	wire per_hit = (period_sel != 3'h0) &&
		(cnt_inc[9:7] == period_sel) && (cnt_inc[6:0] == 7'h00);
	wire ovf_hit = (count_r == 10'h3FF);
	wire mat_hit = (count_r == match_r);
	// in PWM the period comes from whichever comparator the swap bit picks
	wire clr_by_match = is_pwm ? duty_period_swap : clear_src_sel;
	wire duty_hit = duty_period_swap ? per_hit : mat_hit;

	always @(posedge aclk) begin
		if (!aresetn) begin
			div_r <= 8'h00;
			sub_s1_r <= 1'b0;
			sub_s2_r <= 1'b0;
			sub_s3_r <= 1'b0;
			on_d_r <= 1'b0;
			count_r <= `CTPU_RST_COUNT;
			out_r <= 1'b0;
			period_match_evt <= 1'b0;
			match_evt <= 1'b0;
		end else begin
			sub_s1_r <= sub_clk;
			sub_s2_r <= sub_s1_r;
			sub_s3_r <= sub_s2_r;
			on_d_r <= counter_on;
			period_match_evt <= 1'b0;
			match_evt <= 1'b0;
			if (!run || on_rise)
				div_r <= 8'h00;
			else if (tick_src)
				div_r <= (div_r == div_max) ? 8'h00 : div_r + 8'h01;
			if (on_rise) begin
				count_r <= 10'h000;
				if (is_cmp)
					out_r <= out_init_level;
				else if (is_pwm)
					out_r <= 1'b1;
			end else if (run && tick) begin
				period_match_evt <= per_hit | ((period_sel == 3'h0) & ovf_hit);
				match_evt <= mat_hit;
				// period code n matches at n*128; code zero at 1024 by wrap
				if (clr_by_match ? mat_hit : (per_hit | ovf_hit))
					count_r <= 10'h000;
				else
					count_r <= count_r + 10'h001;
				if (is_cmp && mat_hit) begin
					case (out_func_sel)
					`CTPU_FN_LOW: out_r <= 1'b0;
					`CTPU_FN_HIGH: out_r <= 1'b1;
					`CTPU_FN_TOG: out_r <= ~out_r;
					default: out_r <= out_r;
					endcase
				end else if (is_pwm) begin
					// out_r is the active state; level applied below
					if (clr_by_match ? mat_hit : (per_hit | ovf_hit))
						out_r <= 1'b1;
					else if (duty_hit)
						out_r <= 1'b0;
				end
			end
		end
	end

	// pwm function codes: 00 forced inactive, 01 forced active, 10 waveform
	reg pwm_act;
	always @* begin
		case (out_func_sel)
		2'h0: pwm_act = 1'b0;
		2'h1: pwm_act = 1'b1;
		default: pwm_act = out_r;
		endcase
	end
	wire lvl = is_pwm ? (pwm_act ~^ out_init_level) : out_r;
	always @(posedge aclk) begin
		if (!aresetn)
			timer_out <= 1'b0;
		else
			// timer mode just shows the held state, no meaning attached
			timer_out <= lvl ^ out_polarity;
	end
	assign timer_out_inv = ~timer_out;

	// AXI4-Lite slave; write address and data captured independently
	wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
	assign s_axi_awready = ~aw_have_r;
	assign s_axi_wready = ~w_have_r;
	assign s_axi_arready = ~s_axi_rvalid;
	wire [5:0] wa = awaddr_r[5:0];
	wire [5:0] ra = s_axi_araddr[5:0];
	wire wa_ok = (awaddr_r[31:6] == 26'h0) && (wa[1:0] == 2'h0) &&
		(wa <= {1'b0, `CTPU_OFS_MATCH_HIGH});
	wire ra_ok = (s_axi_araddr[31:6] == 26'h0) && (ra[1:0] == 2'h0) &&
		(ra <= {1'b0, `CTPU_OFS_MATCH_HIGH});
	wire ar_go = s_axi_arvalid & ~s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 32'h0000_0000;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CTPU_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `CTPU_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			ctrl_a_r <= `CTPU_RST_CTRL_A;
			ctrl_b_r <= `CTPU_RST_CTRL_B;
			match_r <= `CTPU_RST_MATCH;
			hold_buf_r <= 8'h00;
		end else begin
			if (s_axi_awvalid && !aw_have_r) begin
				awaddr_r <= s_axi_awaddr;
				aw_have_r <= 1'b1;
			end
			if (s_axi_wvalid && !w_have_r) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				w_have_r <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wa_ok ? `CTPU_RESP_OKAY : `CTPU_RESP_SLVERR;
				if (wstrb_r[0]) begin
					case (wa)
					`CTPU_OFS_CTRL_A: ctrl_a_r <= wdata_r[7:0];
					`CTPU_OFS_CTRL_B: ctrl_b_r <= wdata_r[7:0];
					`CTPU_OFS_MATCH_LOW: hold_buf_r <= wdata_r[7:0];
					`CTPU_OFS_MATCH_HIGH:
						match_r <= {wdata_r[1:0], hold_buf_r};
					default: ;
					endcase
				end
			end
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (ar_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= ra_ok ? `CTPU_RESP_OKAY : `CTPU_RESP_SLVERR;
				s_axi_rdata <= 32'h0000_0000;
				case (ra)
				`CTPU_OFS_CTRL_A: s_axi_rdata[7:0] <= ctrl_a_r;
				`CTPU_OFS_CTRL_B: s_axi_rdata[7:0] <= ctrl_b_r;
				`CTPU_OFS_COUNT_LOW, `CTPU_OFS_MATCH_LOW:
					s_axi_rdata[7:0] <= hold_buf_r;
				`CTPU_OFS_COUNT_HIGH: begin
					s_axi_rdata[1:0] <= count_r[9:8];
					hold_buf_r <= count_r[7:0];
				end
				`CTPU_OFS_MATCH_HIGH: begin
					s_axi_rdata[1:0] <= match_r[9:8];
					hold_buf_r <= match_r[7:0];
				end
				default: ;
				endcase
			end
		end
	end
	// a same-cycle write to the buffer and high-byte read: read wins, rare
endmodule
`default_nettype wire

// >>> sim/ctpu_timer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ctpu_timer_bench;
	logic aclk = 0, aresetn = 0, high_clk_en = 0, sub_clk = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, timer_out, timer_out_inv, period_match_evt;
	logic match_evt;
	logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
	logic [31:0] s_axi_rdata, d;
	logic [16:0] lf = 17'h13324;
	logic [9:0] v, c1;
	logic [7:0] s;
	integer fails = 0, check_count = 0, t, n;
	ctpu_timer DUT (.*);
	always #10 aclk = ~aclk;
	function [16:0] nx(input [16:0] x);
		nx = {x[15:0], x[16] ^ x[13]};
	endfunction
	function [10:0] per(input [2:0] c);
		per = (c == 3'h0) ? 11'h400 : {1'b0, c, 7'h00};
	endfunction
	function out_exp(input [1:0] f, input i);
		out_exp = f[0] ? (f[1] & !i) : (f[1] | i);
	endfunction
	// random ticks keep the high and sub clock paths moving
	always @(posedge aclk) begin
		lf <= nx(lf);
		high_clk_en <= lf[0];
		sub_clk <= lf[3];
	end
	task chk(input [31:0] seen, input [31:0] exp, input string nm);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input [31:0] a, input [31:0] x);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= x;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 0;
				br = s_axi_bresp;
			end
		end while (s_axi_bready);
	endtask
	task rd(input [31:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 0;
				d = s_axi_rdata;
				rr = s_axi_rresp;
			end
		end while (s_axi_rready);
	endtask
	// high byte first so the low byte is latched from the same count
	task cnt;
		rd(32'hC);
		c1[9:8] = d[1:0];
		rd(32'h8);
		c1[7:0] = d[7:0];
	endtask
	task cfg(input [7:0] b, input [7:0] a);
		wr(0, 0);
		wr(4, b);
		wr(0, a);
		// output register lags the on-rise by two edges
		repeat (2) @(posedge aclk);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#800000;
		fails++;
		stop_test;
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		rd(0);
		chk(d, 0, "ctrl_a reset");
		rd(4);
		chk(d, 0, "ctrl_b reset");
		for (t = 0; t < 4; t++) begin
			v = t[0] ? lf[9:0] : {10{t[1]}};
			s = {t[1:0], lf[5:0]};
			wr(32'h10, v[7:0]);
			wr(32'h14, v[9:8]);
			wr(32'h10, ~v[7:0]);
			wr(4, s);
			rd(32'h14);
			chk(d, v[9:8], "match_high");
			rd(32'h10);
			chk(d, v[7:0], "match_low");
			rd(4);
			chk(d, s, "ctrl_b");
		end
		rd(32'h18);
		chk(rr, 2'h2, "unmapped rresp");
		wr(32'h18, 1);
		chk(br, 2'h2, "unmapped bresp");
		$display("registers done");
		wr(4, 0);
		for (t = 0; t < 16; t++) begin
			s = t < 8 ? {1'b0, t[2:0], 4'h9} : {5'h03, t[2:0]};
			wr(0, 0);
			wr(0, s);
			n = 0;
			if (t == 6 || t == 7) begin
				repeat (300) @(posedge aclk) n += period_match_evt;
				chk(n, 0, "unusable clock");
			end else if (t < 2 || t > 7) begin
				@(posedge aclk iff period_match_evt);
				do begin
					@(posedge aclk);
					n++;
				end while (!period_match_evt);
				chk(n, t > 7 ? per(t[2:0]) : (t ? 128 : 512), "period");
			end
		end
		$display("period done");
		for (t = 0; t < 2; t++) begin
			cfg(0, 8'h18);
			wr(0, t ? 8'h10 : 8'h98);
			cnt;
			v = c1;
			repeat (40) @(posedge aclk);
			cnt;
			chk(c1, v, "held count");
			wr(0, 8'h18);
			cnt;
			chk(t ? c1 < 40 : c1 > v, 1, "restart");
		end
		$display("pause done");
		wr(32'h10, 8'hC8);
		wr(32'h14, 0);
		for (t = 0; t < 8; t++) begin
			cfg({2'h0, t[1:0], t[2], 3'h1}, 8'h18);
			chk(timer_out, t[2], "init level");
			@(posedge aclk iff match_evt);
			repeat (2) @(posedge aclk);
			chk(timer_out, out_exp(t[1:0], t[2]), "compare out");
		end
		cfg(8'h04, 8'h18);
		chk(timer_out, 1, "polarity");
		cfg(8'hA8, 8'h18);
		chk(timer_out, 1, "pwm start");
		$display("output done");
		stop_test;
	end
endmodule
`default_nettype wire

// >>> sim/ctpu_timer_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ctpu_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic timer_out,
	input wire logic timer_out_inv,
	input wire logic period_match_evt,
	input wire logic match_evt
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_inv;
		timer_out_inv == !timer_out;
	endproperty
	a_inv: assert property (p_inv)
		else $error("inverse output wrong");
	property p_rst;
		$rose(aresetn) |-> !timer_out && !period_match_evt && !match_evt;
	endproperty
	a_rst: assert property (p_rst)
		else $error("timer not idle after reset");
	// fastest period is 128 ticks, so events never crowd each other
	property p_gap;
		period_match_evt |=> !period_match_evt [*8];
	endproperty
	a_gap: assert property (p_gap)
		else $error("period events too close");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data not held");
	property p_rans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rans: assert property (p_rans)
		else $error("read answer late");
	property p_wans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wans: assert property (p_wans)
		else $error("write answer late");
	property p_rerr;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'h14
			|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_rerr: assert property (p_rerr)
		else $error("unmapped read accepted");
	c_per: cover property (period_match_evt);
	c_mat: cover property (match_evt);
	c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind ctpu_timer ctpu_checker u_chk (.*);
`default_nettype wire
